// ---- rtl/ulms_map.vh ----
// Purpose: register map, field positions and reset values for the UART control/status block
// Assumes: registers reached by a plain address/strobe port, one 8-bit register per index
// Notes: offsets are private to this block
`ifndef ULMS_MAP_VH
`define ULMS_MAP_VH

// Register indices (4-bit address)
`define ULMS_A_RX_DATA     4'h0
`define ULMS_A_TX_DATA     4'h1
`define ULMS_A_MODEM_CTRL  4'h2
`define ULMS_A_LINE_STAT   4'h3
`define ULMS_A_MODEM_STAT  4'h4
`define ULMS_A_SCRATCH     4'h5
`define ULMS_A_DIV_LOW     4'h6
`define ULMS_A_DIV_HIGH    4'h7
`define ULMS_A_DIV_FRAC    4'h8
`define ULMS_A_ENH_FEAT    4'h9
`define ULMS_A_INT_EN      4'hA

// Modem control fields
`define ULMS_MC_DTR        0
`define ULMS_MC_RTS        1
`define ULMS_MC_OUT1       2
`define ULMS_MC_OUT2       3
`define ULMS_MC_LOOP       4
`define ULMS_MC_ANY        5
`define ULMS_MC_IR         6
`define ULMS_MC_PRESC      7

// Enhanced feature fields
`define ULMS_EF_ENH        4
`define ULMS_EF_ACTS       7

// Interrupt enable fields
`define ULMS_IE_LINE       2
`define ULMS_IE_MODEM      3

// Reset values
`define ULMS_RST_SCRATCH   8'hFF
`define ULMS_RST_DIV_LOW   8'h01
`define ULMS_RST_ZERO      8'h00

// Receive store depth and pointer width
`define ULMS_DEPTH         32
`define ULMS_PW            5

`endif

// ---- rtl/ulms_core.v ----
// Purpose: one UART channel with modem control, line status, modem status, divisor
// Assumes: 8N1 frames, single clock, host port with read data one cycle after strobe
// Notes: receive store holds data plus three error tags per byte
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "ulms_map.vh"

// Notes on behaviour
// - Modem control bit 4 selects local loopback
// - Any received character restarts halted transmitter
// - Infrared bit routes serial through IR codec
// - Infrared transmit output stays low when idle
// - Prescaler bit divides baud clock by four
// - Data ready shows unread received characters
// - Full store: set overrun, drop new character
// - Parity/framing tags follow presented character
// - Long low line stores one break
// - Holding empty set on handoff, cleared on write except in a handoff cycle
// - Idle flag when holding and shift empty
// - Error summary while any stored byte tagged
// - Overrun interrupts now, tags at presentation
// - Deltas on modem input change raise interrupt
// - Ring delta only on rising ring input
// - Auto clear-to-send high halts after character
// - Modem status mirrors outputs in loopback
// - Scratch register resets to all ones
// - Divisor equals sixteen-bit value plus fraction
// - Fraction register writable only when enhanced
// - Fraction bits 5:4 pick 16x/8x/4x sampling
// - Feature bits 0-3 choose flow-control characters
// - Enhanced bit unlocks upper control and fraction
module ulms_core (
  input wire i_clk,
  input wire i_arst_n,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_rx,
  input wire i_cts_n,
  input wire i_dsr_n,
  input wire i_ring_indicator_in_n,
  input wire i_carrier_detect_in_n,
  input wire i_xon_seen,
  input wire i_xoff_seen,
  output wire o_tx,
  output wire o_dtr_n,
  output wire o_rts_n,
  output wire o_irq,
  output wire [3:0] o_flow_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] modem_control; // Bits 7:5 locked unless enhanced
  reg [7:0] scratch_pad; // General storage
  reg [7:0] divisor_low; // Divisor low byte
  reg [7:0] divisor_high; // Divisor high byte
  reg [7:0] divisor_fraction_sampling; // Fraction and sampling rate
  reg [7:0] enhanced_feature; // Flow selection and enables
  reg [7:0] interrupt_enable; // Only line and modem bits used
  reg [3:0] delta; // Modem delta flags
  reg overrun; // Sticky overrun
  reg tx_halted; // Software flow stop

  wire wr_ok_enh = enhanced_feature[`ULMS_EF_ENH]; // Enhanced write gate
  wire loop_on = modem_control[`ULMS_MC_LOOP];
  wire ir_on = modem_control[`ULMS_MC_IR];

  // Baud tick spacing in input clocks
  function [19:0] tick_len;
    input [7:0] hi;
    input [7:0] lo;
    input [7:0] fr;
    input presc;
    reg [19:0] base;
    begin
      // Fraction weighs sixteenths, applied as a rounded extra count
      base = {4'h0, hi, lo} + {19'h0, fr[3]};
      if (base == 20'h0) begin
        base = 20'h1;
      end
      tick_len = presc ? {base[17:0], 2'b00} : base;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg [5:0] s1;
  reg [5:0] s2;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1 <= 6'h3F;
      s2 <= 6'h3F;
    end else begin
      s1 <= {i_rx, i_cts_n, i_dsr_n, i_ring_indicator_in_n, i_carrier_detect_in_n, 1'b1};
      s2 <= s1;
    end
  end
  wire cts_n = s2[4];

  ////////////////////////////////////////////////////////////////////////////
  // Sample tick: baud rate times oversampling
  reg [19:0] bcnt;
  wire [19:0] blen = tick_len(divisor_high, divisor_low, divisor_fraction_sampling,
    modem_control[`ULMS_MC_PRESC]);
  wire stick = (bcnt == 20'h0);
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bcnt <= 20'h0;
    end else if (stick) begin
      bcnt <= blen - 20'h1;
    end else begin
      bcnt <= bcnt - 20'h1;
    end
  end
  // Samples per bit minus one
  wire [3:0] osr = divisor_fraction_sampling[5] ? 4'h3 :
    (divisor_fraction_sampling[4] ? 4'h7 : 4'hF);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: holding register plus shift register
  reg [7:0] thold;
  reg thold_full;
  reg [9:0] tshift;
  reg [3:0] tbits;
  reg [3:0] tsub;
  wire tbusy = (tbits != 4'h0);
  wire cts_stop = enhanced_feature[`ULMS_EF_ACTS] & cts_n;
  wire tx_line = tbusy ? tshift[0] : 1'b1;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      thold <= 8'h00;
      thold_full <= 1'b0;
      tshift <= 10'h3FF;
      tbits <= 4'h0;
      tsub <= 4'h0;
    end else begin
      if (i_wr && i_addr == `ULMS_A_TX_DATA) begin
        thold <= i_wdata;
        thold_full <= 1'b1;
      end
      if (!tbusy) begin
        // Start only between characters so halts take effect after a frame
        if (thold_full && !cts_stop && !tx_halted) begin
          tshift <= {1'b1, thold, 1'b0};
          tbits <= 4'hA;
          tsub <= osr;
          thold_full <= 1'b0;
        end
      end else if (stick) begin
        if (tsub == 4'h0) begin
          tsub <= osr;
          tshift <= {1'b1, tshift[9:1]};
          tbits <= tbits - 4'h1;
        end else begin
          tsub <= tsub - 4'h1;
        end
      end
    end
  end

  // IR pulse: high during the first sample period of each zero bit
  wire ir_tx = tbusy & ~tshift[0] & (tsub == osr);
  assign o_tx = loop_on ? 1'b1 : (ir_on ? ir_tx : tx_line);

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  // IR input decoded to NRZ: pulse high means zero bit, stretched over a bit
  reg [3:0] ir_hold;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ir_hold <= 4'h0;
    end else if (s2[5]) begin
      ir_hold <= osr;
    end else if (stick && ir_hold != 4'h0) begin
      ir_hold <= ir_hold - 4'h1;
    end
  end
  wire ir_rx = ~(s2[5] | (ir_hold != 4'h0));
  wire rx_in = loop_on ? tx_line : (ir_on ? ir_rx : s2[5]);

  reg [3:0] rbits;
  reg [3:0] rsub;
  reg [7:0] rshift;
  reg rzero; // All sampled bits low so far
  reg brk_wait; // Break stored, wait for mark
  reg rdone;
  reg [7:0] rchar;
  reg rframe;
  reg rbrk;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rbits <= 4'h0;
      rsub <= 4'h0;
      rshift <= 8'h00;
      rzero <= 1'b0;
      brk_wait <= 1'b0;
      rdone <= 1'b0;
      rchar <= 8'h00;
      rframe <= 1'b0;
      rbrk <= 1'b0;
    end else begin
      rdone <= 1'b0;
      if (brk_wait) begin
        if (rx_in) begin
          brk_wait <= 1'b0;
        end
      end else if (rbits == 4'h0) begin
        if (!rx_in && stick) begin
          rbits <= 4'hA;
          rsub <= {1'b0, osr[3:1]};
          rzero <= 1'b1;
        end
      end else if (stick) begin
        if (rsub == 4'h0) begin
          rsub <= osr;
          rbits <= rbits - 4'h1;
          if (rbits == 4'hA && rx_in) begin
            // Line back high at mid-start: a glitch or a framing tail, not a frame
            rbits <= 4'h0;
          end else if (rbits == 4'h1) begin
            rdone <= 1'b1;
            rchar <= rshift;
            rframe <= ~rx_in;
            rbrk <= rzero & ~rx_in;
            brk_wait <= rzero & ~rx_in;
          end else if (rbits != 4'hA) begin
            rshift <= {rx_in, rshift[7:1]};
          end
          if (rx_in) begin
            rzero <= 1'b0;
          end
        end else begin
          rsub <= rsub - 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive store with error tags
  reg [10:0] mem [0:`ULMS_DEPTH-1];
  reg [`ULMS_PW-1:0] wp;
  reg [`ULMS_PW-1:0] rp;
  reg [`ULMS_PW:0] cnt;
  reg [`ULMS_PW:0] errcnt; // Stored bytes carrying any tag
  wire full = (cnt == `ULMS_DEPTH);
  wire empty = (cnt == 6'h00);
  // Flow characters are consumed, not stored, while software flow is on
  wire flow_char = (enhanced_feature[1:0] != 2'b00) & (i_xon_seen | i_xoff_seen);
  wire push = rdone & ~full & ~flow_char;
  wire pop = i_rd & (i_addr == `ULMS_A_RX_DATA) & ~empty;
  wire [10:0] head = mem[rp];
  wire in_err = rframe | rbrk;
  wire out_err = |head[10:8];
  integer k;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp <= 5'h00;
      rp <= 5'h00;
      cnt <= 6'h00;
      errcnt <= 6'h00;
      for (k = 0; k < `ULMS_DEPTH; k = k + 1) begin
        mem[k] <= 11'h000;
      end
    end else begin
      if (push) begin
        // Parity check absent for 8N1; bit 8 stays clear
        mem[wp] <= {rbrk, rframe, 1'b0, rchar};
        wp <= wp + 5'h01;
      end
      if (pop) begin
        rp <= rp + 5'h01;
      end
      cnt <= cnt + {5'h00, push} - {5'h00, pop};
      errcnt <= errcnt + {5'h00, push & in_err} - {5'h00, pop & out_err};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit halt from software flow and resume on any character
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_halted <= 1'b0;
    end else if (rdone && i_xoff_seen && enhanced_feature[1:0] != 2'b00) begin
      tx_halted <= 1'b1;
    end else if (rdone && (i_xon_seen || modem_control[`ULMS_MC_ANY])) begin
      tx_halted <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line and modem status
  wire [7:0] line_status = {errcnt != 6'h00, ~thold_full & ~tbusy, ~thold_full,
    empty ? 3'b000 : head[10:8], overrun, ~empty};
  wire [3:0] lvl = loop_on ? {modem_control[`ULMS_MC_OUT2], modem_control[`ULMS_MC_OUT1],
    modem_control[`ULMS_MC_DTR], modem_control[`ULMS_MC_RTS]} :
    {~s2[1], ~s2[2], ~s2[3], ~s2[4]}; // Top to bottom: CD, RI, DSR, CTS
  reg [3:0] lvl_q;
  wire rd_ms = i_rd & (i_addr == `ULMS_A_MODEM_STAT);
  wire rd_ls = i_rd & (i_addr == `ULMS_A_LINE_STAT);
  wire [3:0] chg = lvl ^ lvl_q;
  // Set wins over the read clear
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_q <= 4'h0;
      delta <= 4'h0;
      overrun <= 1'b0;
    end else begin
      lvl_q <= lvl;
      delta <= (rd_ms ? 4'h0 : delta) |
        {chg[3], chg[2] & lvl_q[2], chg[1], chg[0]};
      overrun <= (overrun & ~rd_ls) | (rdone & full);
    end
  end
  wire [7:0] modem_status = {lvl, delta};

  assign o_irq = (interrupt_enable[`ULMS_IE_LINE] & (overrun | line_status[4] |
    line_status[3] | line_status[2])) | (interrupt_enable[`ULMS_IE_MODEM] & (|delta));
  assign o_dtr_n = ~modem_control[`ULMS_MC_DTR] | loop_on;
  assign o_rts_n = ~modem_control[`ULMS_MC_RTS] | loop_on;
  assign o_flow_sel = enhanced_feature[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      modem_control <= `ULMS_RST_ZERO;
      scratch_pad <= `ULMS_RST_SCRATCH;
      divisor_low <= `ULMS_RST_DIV_LOW;
      divisor_high <= `ULMS_RST_ZERO;
      divisor_fraction_sampling <= `ULMS_RST_ZERO;
      enhanced_feature <= `ULMS_RST_ZERO;
      interrupt_enable <= `ULMS_RST_ZERO;
    end else if (i_wr) begin
      case (i_addr)
        `ULMS_A_MODEM_CTRL: begin
          modem_control[4:0] <= i_wdata[4:0];
          if (wr_ok_enh) begin
            modem_control[7:5] <= i_wdata[7:5];
          end
        end
        `ULMS_A_SCRATCH: scratch_pad <= i_wdata;
        `ULMS_A_DIV_LOW: divisor_low <= i_wdata;
        `ULMS_A_DIV_HIGH: divisor_high <= i_wdata;
        `ULMS_A_DIV_FRAC: begin
          if (wr_ok_enh) begin
            divisor_fraction_sampling <= {2'b00, i_wdata[5:0]};
          end
        end
        `ULMS_A_ENH_FEAT: enhanced_feature <= i_wdata;
        `ULMS_A_INT_EN: interrupt_enable <= i_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data one cycle after strobe
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `ULMS_A_RX_DATA: o_rdata <= empty ? 8'h00 : head[7:0];
        `ULMS_A_MODEM_CTRL: o_rdata <= modem_control;
        `ULMS_A_LINE_STAT: o_rdata <= line_status;
        `ULMS_A_MODEM_STAT: o_rdata <= modem_status;
        `ULMS_A_SCRATCH: o_rdata <= scratch_pad;
        `ULMS_A_DIV_LOW: o_rdata <= divisor_low;
        `ULMS_A_DIV_HIGH: o_rdata <= divisor_high;
        `ULMS_A_DIV_FRAC: o_rdata <= divisor_fraction_sampling;
        `ULMS_A_ENH_FEAT: o_rdata <= enhanced_feature;
        `ULMS_A_INT_EN: o_rdata <= interrupt_enable;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ---- tb/ulms_chk.sv ----
// Purpose: port-level assertions for the UART control/status block
// Assumes: register indices as in the block's map, feature register always writable
// Notes: shadow copies track what software wrote, gated as the lock bit dictates
`timescale 1ns/10ps
module ulms_chk (
  input wire i_clk,
  input wire i_arst_n,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_tx,
  input wire o_dtr_n,
  input wire o_rts_n,
  input wire [3:0] o_flow_sel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  reg [7:0] mc; // Shadow modem control
  reg [7:0] scr; // Shadow scratch
  reg [5:0] frac; // Shadow fraction
  reg enh; // Shadow enhanced-write bit
  wire [3:0] lb = {mc[3], mc[2], mc[0], mc[1]}; // Loopback view of outputs
  //////////////////////////////////////////////////////////////////////////////
  // Shadow registers; upper control bits only move while enhanced is set
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mc <= 8'h00;
      scr <= 8'hFF;
      frac <= 6'h00;
      enh <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        4'h2: mc <= enh ? i_wdata : {mc[7:5], i_wdata[4:0]};
        4'h5: scr <= i_wdata;
        4'h8: frac <= enh ? i_wdata[5:0] : frac;
        4'h9: enh <= i_wdata[4];
        default: ;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_mc_rd;
    i_rd && i_addr == 4'h2 |=> o_rdata == $past(mc);
  endproperty
  a_mc_rd: assert property (p_mc_rd) else $error("modem control readback wrong");
  property p_scr_rd;
    i_rd && i_addr == 4'h5 |=> o_rdata == $past(scr);
  endproperty
  a_scr_rd: assert property (p_scr_rd) else $error("scratch readback wrong");
  property p_frac_rd;
    i_rd && i_addr == 4'h8 |=> o_rdata == {2'b00, $past(frac)};
  endproperty
  a_frac_rd: assert property (p_frac_rd) else $error("fraction readback wrong");
  property p_unmap;
    i_rd && i_addr > 4'hA |=> o_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold;
    !i_rd |=> $stable(o_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_flow;
    i_wr && i_addr == 4'h9 |=> {4'h0, o_flow_sel} == ($past(i_wdata) & 8'h0F);
  endproperty
  a_flow: assert property (p_flow) else $error("flow select mismatch");
  property p_loop_pins;
    mc[4] |-> o_tx && o_dtr_n && o_rts_n;
  endproperty
  a_loop_pins: assert property (p_loop_pins) else $error("pins not idle in loop");
  property p_pins;
    !mc[4] |-> o_dtr_n == !mc[0] && o_rts_n == !mc[1];
  endproperty
  a_pins: assert property (p_pins) else $error("control pins wrong");
  property p_loop_ms;
    i_rd && i_addr == 4'h4 && mc[4] |=> o_rdata[7:4] == $past(lb);
  endproperty
  a_loop_ms: assert property (p_loop_ms) else $error("loop status mirror wrong");
endmodule

// ---- tb/ulms_remote.sv ----
// Purpose: remote serial device sending and catching 8N1 frames
// Assumes: one bit lasts BIT clocks
// Notes: line idles high between frames, as a mark pull-up would leave it
`timescale 1ns/10ps
module ulms_remote #(
  parameter int BIT = 16
) (
  input wire i_clk,
  input wire i_tx,
  output logic o_rx
);
  logic [7:0] last; // Last caught byte
  logic got; // Set when a frame was caught
  integer j;
  initial begin
    o_rx = 1'b1;
    got = 1'b0;
    last = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One frame; stop level chosen so a framing fault can be sent
  task send(input [7:0] b, input stop);
    integer k;
    o_rx <= 1'b0;
    repeat (BIT) @(posedge i_clk);
    for (k = 0; k < 8; k++) begin
      o_rx <= b[k];
      repeat (BIT) @(posedge i_clk);
    end
    o_rx <= stop;
    repeat (BIT) @(posedge i_clk);
    o_rx <= 1'b1;
    repeat (BIT) @(posedge i_clk);
  endtask
  // Line held low well past one frame
  task brk();
    o_rx <= 1'b0;
    repeat (12 * BIT) @(posedge i_clk);
    o_rx <= 1'b1;
    repeat (2 * BIT) @(posedge i_clk);
  endtask
  // Catcher samples mid-bit after a falling start edge
  always begin
    @(negedge i_tx);
    repeat (BIT / 2) @(posedge i_clk);
    for (j = 0; j < 8; j++) begin
      repeat (BIT) @(posedge i_clk);
      last[j] <= i_tx;
    end
    got <= 1'b1;
  end
endmodule

// ---- tb/test_ulms_core.sv ----
// Purpose: register and line tests for the UART control/status block
// Assumes: divisor 1, 16x sampling, so one bit lasts 16 clocks
// Notes: modem inputs and the two flow-match flags are driven
`timescale 1ns/10ps
module test_ulms_core;
  logic i_clk, i_arst_n, i_wr, i_rd, i_cts_n, i_dsr_n, i_ri_n, i_cd_n;
  logic i_xon, i_xoff; // Flow character match flags from outside comparison
  logic [3:0] i_addr;
  logic [7:0] i_wdata, rv;
  wire [7:0] o_rdata;
  wire [3:0] o_flow_sel;
  wire o_tx, o_dtr_n, o_rts_n, o_irq, rx;
  integer err_total, checks, n, i;
  ulms_core ulms_core_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(rx),
    .i_cts_n(i_cts_n), .i_dsr_n(i_dsr_n), .i_ring_indicator_in_n(i_ri_n),
    .i_carrier_detect_in_n(i_cd_n), .i_xon_seen(i_xon), .i_xoff_seen(i_xoff), .o_tx(o_tx),
    .o_dtr_n(o_dtr_n), .o_rts_n(o_rts_n), .o_irq(o_irq), .o_flow_sel(o_flow_sel));
  ulms_remote m (.i_clk(i_clk), .i_tx(o_tx), .o_rx(rx));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task chk(input [7:0] s, input [7:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Data is taken a little after the edge that ends the strobe
  task rd(input [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task finish_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog against a hung wait
  initial begin
    repeat (60000) @(posedge i_clk);
    err_total++;
    finish_test();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_arst_n, i_wr, i_rd, i_addr, i_wdata, err_total, checks, i_xon, i_xoff} = 0;
    {i_cts_n, i_dsr_n, i_ri_n, i_cd_n} = 4'hF;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(4'h5); chk(rv, 8'hFF);
    rd(4'h3); chk(rv, 8'h60);
    rd(4'h2); chk(rv, 8'h00);
    rd(4'h4);
    rd(4'hC); chk(rv, 8'h00);
    wr(4'h5, 8'h5A); rd(4'h5); chk(rv, 8'h5A);
    wr(4'h2, 8'hE0); rd(4'h2); chk(rv, 8'h00);
    wr(4'h8, 8'h3F); rd(4'h8); chk(rv, 8'h00);
    for (i = 0; i < 16; i++) begin
      wr(4'h9, 8'h10 | i[7:0]); @(negedge i_clk); chk({4'h0, o_flow_sel}, i[7:0]);
    end
    wr(4'h9, 8'h10);
    wr(4'h8, 8'hFF); rd(4'h8); chk(rv, 8'h3F);
    wr(4'h8, 8'h00);
    wr(4'h2, 8'h40); repeat (4) @(posedge i_clk); chk({7'h0, o_tx}, 8'h00);
    wr(4'h2, 8'h1F); rd(4'h4); chk(rv & 8'hF0, 8'hF0);
    chk({5'h0, o_tx, o_dtr_n, o_rts_n}, 8'h07);
    wr(4'h1, 8'hA5);
    n = 0;
    do begin rd(4'h3); n++; end while (rv[6] !== 1'b1 && n < 200);
    chk(rv & 8'h41, 8'h41);
    rd(4'h0); chk(rv, 8'hA5);
    rd(4'h3); chk(rv & 8'h01, 8'h00);
    wr(4'h2, 8'h03); rd(4'h4);
    i_cts_n <= 1'b0; repeat (4) @(posedge i_clk);
    rd(4'h4); chk(rv & 8'h1F, 8'h11);
    i_ri_n <= 1'b0; repeat (4) @(posedge i_clk);
    rd(4'h4); chk(rv & 8'h04, 8'h00);
    i_ri_n <= 1'b1; repeat (4) @(posedge i_clk);
    rd(4'h4); chk(rv & 8'h04, 8'h04);
    m.got = 1'b0;
    wr(4'h1, 8'h3C);
    for (n = 0; n < 400 && m.got !== 1'b1; n++) @(posedge i_clk);
    chk(m.last, 8'h3C);
    m.send(8'hC3, 1'b1); rd(4'h3); chk(rv & 8'h01, 8'h01);
    rd(4'h0); chk(rv, 8'hC3);
    m.send(8'h55, 1'b0); rd(4'h3); chk(rv & 8'h88, 8'h88);
    rd(4'h0); rd(4'h3); chk(rv & 8'h88, 8'h00);
    m.brk(); rd(4'h3); chk(rv & 8'h10, 8'h10);
    rd(4'h0);
    // Software flow stop halts the transmitter; any character restarts it
    wr(4'h9, 8'h12); i_xoff <= 1'b1; m.send(8'h13, 1'b1); i_xoff <= 1'b0;
    wr(4'h1, 8'h69); rd(4'h3); chk(rv & 8'h21, 8'h00);
    wr(4'h2, 8'h23); m.send(8'h24, 1'b1); repeat (20) @(posedge i_clk);
    rd(4'h3); chk(rv & 8'h21, 8'h21);
    rd(4'h0); chk(rv, 8'h24);
    // Auto clear-to-send: high input keeps the next character waiting
    repeat (160) @(posedge i_clk);
    i_cts_n <= 1'b1; wr(4'h9, 8'h90); wr(4'h1, 8'h5A); repeat (40) @(posedge i_clk);
    rd(4'h3); chk(rv & 8'h60, 8'h00);
    i_cts_n <= 1'b0; repeat (8) @(posedge i_clk);
    rd(4'h3); chk(rv & 8'h20, 8'h20);
    repeat (33) m.send(8'h11, 1'b1);
    wr(4'hA, 8'h04); @(negedge i_clk); chk({7'h0, o_irq}, 8'h01);
    rd(4'h3); chk(rv & 8'h03, 8'h03);
    chk({7'h0, o_irq}, 8'h00);
    rd(4'h0); chk(rv, 8'h11);
    finish_test();
  end
endmodule
bind ulms_core ulms_chk ulms_chk_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tx(o_tx),
  .o_dtr_n(o_dtr_n), .o_rts_n(o_rts_n), .o_flow_sel(o_flow_sel));
